// file: rtl/temp_sensor_serial_control.sv
// Serial interface and conversion control of the temperature sensor.
// Overview of operation
// - Device acknowledges that code and switches filters to high-speed, up to 3.4MHz.
// - High-speed operation holds until STOP, then filters return to fast mode.
// - SCL or SDA low about 30ms inside a transfer resets the interface.
// - On that timeout the device releases the bus and waits for START.
// - Power-down bit high: finish current conversion, then stop converting.
// - Power-down bit low: conversions run back to back.
// - Shorted remote inputs give the fixed result -64h.
// - Fault comparator watched over a conversion; fault sets result bit 0.
// - Invalid supply skips conversions and sets result bit 1.
// - General call address 00h is acknowledged; next byte is interpreted.
// - General call byte 06h resets registers and aborts the conversion.
// - Other general call bytes are acknowledged only.
// - First written byte is the pointer; reads use the last pointer.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_serial_control #(
    parameter int STUCK_LIMIT = tsense_pkg::STUCK_CYCLES, // Bus-stuck cycles.
    parameter int CONV_LEN    = tsense_pkg::CONV_CYCLES   // Cycles per conversion.
) (
    input  wire logic              CLOCK,      // System clock, 100 MHz.
    input  wire logic              RESET,      // Asynchronous reset, high.
    input  wire logic              SCL_I,      // Bus clock level.
    input  wire logic              SDA_I,      // Bus data level.
    output logic                   SDA_O,      // Data driven value, always low.
    output logic                   SDA_OE,     // High while pulling data low.
    input  wire tsense_pkg::sense_s SENSE,     // Comparator levels.
    input  wire logic [7:0]        ADC_DATA,   // Raw conversion value.
    output logic                   HS_MODE,    // High-speed filter select.
    output logic                   CONV_BUSY,  // Conversion in progress.
    output logic                   ANALOG_ON,  // Analog section powered.
    output logic [7:0]             TEMP_RESULT // Latest temperature result.
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]         scl_s;
        logic [1:0]         sda_s;
        logic               scl_p;
        logic               sda_p;
        tsense_pkg::phase_e ph;
        logic [7:0]         shift;
        logic [3:0]         bitn;
        logic               first;
        logic               gcall;
        logic               rd;
        logic               hs;
        logic               in_xfer;
        logic [31:0]        stuck;
        logic [31:0]        stuck_sda;
        logic               drive;
        logic [7:0]         ptr;
        logic [7:0]         cfg;
        logic [7:0]         tx;
        tsense_pkg::conv_e  cv;
        logic [31:0]        ccnt;
        logic               open_seen;
        logic [7:0]         result;
    } st_s;

    st_s q, d;

    // Bus sampling and edge detection work on the second stage only.
    logic scl, sda, scl_rise, scl_fall, start_c, stop_c, sw_reset;
    assign scl      = q.scl_s[1];
    assign sda      = q.sda_s[1];
    assign scl_rise = scl & ~q.scl_p;
    assign scl_fall = ~scl & q.scl_p;
    assign start_c  = scl & q.scl_p & q.sda_p & ~sda;
    assign stop_c   = scl & q.scl_p & ~q.sda_p & sda;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // One process covers protocol, timeout and conversion so that the
    // software reset can clear the registers and the conversion in a single cycle.
    always_comb begin
        d           = q;
        sw_reset    = 1'b0;
        d.scl_s     = {q.scl_s[0], SCL_I};
        d.sda_s     = {q.sda_s[0], SDA_I};
        d.scl_p     = scl;
        d.sda_p     = sda;

        // Bus-stuck timers, one per line, counting only inside a transfer. Each line has
        // its own timer, so a long run of zero bits on a running clock still trips the data timer.
        if (q.in_xfer && !scl) begin
            d.stuck = q.stuck + 32'h0000_0001;
        end else begin
            d.stuck = 32'h0000_0000;
        end
        if (q.in_xfer && !sda) begin
            d.stuck_sda = q.stuck_sda + 32'h0000_0001;
        end else begin
            d.stuck_sda = 32'h0000_0000;
        end

        // Protocol engine steps on SCL edges.
        unique case (q.ph)
            tsense_pkg::PH_IDLE: begin
                d.drive = 1'b0;
            end
            tsense_pkg::PH_ADDR, tsense_pkg::PH_WBYTE: begin
                if (scl_rise) begin
                    d.shift = {q.shift[6:0], sda};
                    d.bitn  = q.bitn + 4'h1;
                end
                if (scl_fall && q.bitn == 4'h8) begin
                    d.bitn = 4'h0;
                    if (q.ph == tsense_pkg::PH_ADDR) begin
                        if (q.shift[7:3] == tsense_pkg::HS_CODE_TOP) begin
                            d.hs    = 1'b1;
                            d.drive = 1'b1;
                            d.ph    = tsense_pkg::PH_AACK;
                        end else if (q.shift == tsense_pkg::GEN_CALL_ADDR) begin
                            d.gcall = 1'b1;
                            d.drive = 1'b1;
                            d.ph    = tsense_pkg::PH_AACK;
                        end else if (q.shift[7:1] == tsense_pkg::SLAVE_ADDR) begin
                            d.rd    = q.shift[0];
                            d.drive = 1'b1;
                            d.first = 1'b1;
                            d.ph    = tsense_pkg::PH_AACK;
                        end else begin
                            d.ph = tsense_pkg::PH_IDLE;
                        end
                    end else begin
                        d.drive = 1'b1;
                        d.ph    = tsense_pkg::PH_WACK;
                        if (q.gcall) begin
                            sw_reset = (q.shift == tsense_pkg::SW_RESET_CODE);
                        end else if (q.first) begin
                            d.ptr   = q.shift;
                            d.first = 1'b0;
                        end else if (q.ptr == tsense_pkg::PTR_CFG) begin
                            d.cfg = q.shift;
                        end
                    end
                end
            end
            tsense_pkg::PH_AACK, tsense_pkg::PH_WACK: begin
                if (scl_fall) begin
                    d.drive = 1'b0;
                    if (q.ph == tsense_pkg::PH_AACK && q.rd) begin
                        d.tx    = (q.ptr == tsense_pkg::PTR_CFG) ? q.cfg : q.result;
                        d.drive = ~((q.ptr == tsense_pkg::PTR_CFG) ? q.cfg[7] : q.result[7]);
                        d.bitn  = 4'h1;
                        d.ph    = tsense_pkg::PH_RBYTE;
                    end else if (q.ph == tsense_pkg::PH_AACK && !q.gcall && !q.rd
                                 && !q.first) begin
                        d.ph = tsense_pkg::PH_ADDR;  // Master code ack; address follows.
                    end else begin
                        d.ph = tsense_pkg::PH_WBYTE;
                    end
                end
            end
            tsense_pkg::PH_RBYTE: begin
                if (scl_fall) begin
                    if (q.bitn == 4'h8) begin
                        d.drive = 1'b0;
                        d.bitn  = 4'h0;
                        d.ph    = tsense_pkg::PH_RACK;
                    end else begin
                        d.tx    = {q.tx[6:0], 1'b0};
                        d.drive = ~q.tx[6];
                        d.bitn  = q.bitn + 4'h1;
                    end
                end
            end
            tsense_pkg::PH_RACK: begin
                // A low acknowledge asks for the same register again.
                if (scl_rise) begin
                    d.first = sda;
                end
                if (scl_fall) begin
                    if (q.first) begin
                        d.ph = tsense_pkg::PH_IDLE;
                    end else begin
                        d.tx    = (q.ptr == tsense_pkg::PTR_CFG) ? q.cfg : q.result;
                        d.drive = ~((q.ptr == tsense_pkg::PTR_CFG) ? q.cfg[7] : q.result[7]);
                        d.bitn  = 4'h1;
                        d.ph    = tsense_pkg::PH_RBYTE;
                    end
                end
            end
        endcase

        // START and STOP override any phase.
        if (start_c) begin
            d.ph      = tsense_pkg::PH_ADDR;
            d.bitn    = 4'h0;
            d.gcall   = 1'b0;
            d.rd      = 1'b0;
            d.first   = 1'b0;
            d.drive   = 1'b0;
            d.in_xfer = 1'b1;
        end
        if (stop_c) begin
            d.ph      = tsense_pkg::PH_IDLE;
            d.hs      = 1'b0;
            d.drive   = 1'b0;
            d.in_xfer = 1'b0;
        end

        // Timeout drops the interface and any held line.
        if (q.stuck >= 32'(STUCK_LIMIT - 1) || q.stuck_sda >= 32'(STUCK_LIMIT - 1)) begin
            d.ph        = tsense_pkg::PH_IDLE;
            d.drive     = 1'b0;
            d.in_xfer   = 1'b0;
            d.stuck     = 32'h0000_0000;
            d.stuck_sda = 32'h0000_0000;
        end

        // Conversion engine.
        unique case (q.cv)
            tsense_pkg::CV_IDLE: begin
                if (!q.cfg[tsense_pkg::CFG_PD_BIT]) begin
                    if (SENSE.supply_bad) begin
                        d.result[tsense_pkg::SUPPLY_BIT] = 1'b1;
                    end else begin
                        d.cv        = tsense_pkg::CV_RUN;
                        d.ccnt      = 32'h0000_0000;
                        d.open_seen = 1'b0;
                    end
                end else begin
                    d.cv = tsense_pkg::CV_DOWN;
                end
            end
            tsense_pkg::CV_RUN: begin
                d.ccnt = q.ccnt + 32'h0000_0001;
                if (SENSE.open_fault) begin
                    d.open_seen = 1'b1;
                end
                if (q.ccnt >= 32'(CONV_LEN - 1)) begin
                    if (SENSE.short_fault) begin
                        d.result = tsense_pkg::SHORT_RESULT;
                    end else begin
                        d.result = {ADC_DATA[7:2], 1'b0, 1'b0};
                    end
                    d.result[tsense_pkg::OPEN_BIT]   = q.open_seen | SENSE.open_fault;
                    d.result[tsense_pkg::SUPPLY_BIT] = SENSE.supply_bad;
                    d.cv = q.cfg[tsense_pkg::CFG_PD_BIT] ? tsense_pkg::CV_DOWN
                                                         : tsense_pkg::CV_RUN;
                    d.ccnt      = 32'h0000_0000;
                    d.open_seen = 1'b0;
                end
            end
            tsense_pkg::CV_DOWN: begin
                if (!q.cfg[tsense_pkg::CFG_PD_BIT]) begin
                    d.cv = tsense_pkg::CV_IDLE;
                end
            end
        endcase
        if (q.cv == tsense_pkg::CV_RUN && SENSE.supply_bad) begin
            d.cv                             = tsense_pkg::CV_IDLE;
            d.result[tsense_pkg::SUPPLY_BIT] = 1'b1;
        end

        // Software reset restores power-on values and aborts conversion.
        if (sw_reset) begin
            d.ptr       = tsense_pkg::PTR_RESET;
            d.cfg       = tsense_pkg::CFG_RESET;
            d.cv        = tsense_pkg::CV_IDLE;
            d.ccnt      = 32'h0000_0000;
            d.open_seen = 1'b0;
            d.result    = 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Lines idle high, so the synchronisers reset high to avoid a false START.
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            q        <= '0;
            q.scl_s  <= 2'b11;
            q.sda_s  <= 2'b11;
            q.scl_p  <= 1'b1;
            q.sda_p  <= 1'b1;
            q.ph     <= tsense_pkg::PH_IDLE;
            q.cv     <= tsense_pkg::CV_IDLE;
            q.ptr    <= tsense_pkg::PTR_RESET;
            q.cfg    <= tsense_pkg::CFG_RESET;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Open-drain: the pin is only ever pulled low.
    assign SDA_O       = 1'b0;
    assign SDA_OE      = q.drive;
    assign HS_MODE     = q.hs;
    assign CONV_BUSY   = (q.cv == tsense_pkg::CV_RUN);
    assign ANALOG_ON   = (q.cv != tsense_pkg::CV_DOWN);
    assign TEMP_RESULT = q.result;

endmodule : temp_sensor_serial_control
`default_nettype wire

// file: rtl/tsense_pkg.sv
// Shared constants and carrier types for the temperature sensor serial control block.
package tsense_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ          = 100_000_000;
    localparam int STUCK_TIME_MS   = 30;
    localparam int STUCK_CYCLES    = (CLK_HZ / 1000) * STUCK_TIME_MS;
    localparam int CONV_CYCLES     = 1000;

    // ------------------------------------------------------------------
    // Bus codes
    // ------------------------------------------------------------------
    localparam logic [4:0] HS_CODE_TOP   = 5'h01;
    localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
    localparam logic [7:0] SW_RESET_CODE = 8'h06;
    localparam logic [6:0] SLAVE_ADDR    = 7'h4C;

    // ------------------------------------------------------------------
    // Result and config layout, register pointers and reset values
    // ------------------------------------------------------------------
    localparam int         OPEN_BIT      = 0;
    localparam int         SUPPLY_BIT    = 1;
    localparam logic [7:0] SHORT_RESULT  = 8'h9C;
    localparam logic [7:0] PTR_RESET     = 8'h00;
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam int         CFG_PD_BIT    = 6;
    localparam logic [7:0] PTR_CFG       = 8'h09;
    localparam logic [7:0] PTR_TEMP      = 8'h00;
    localparam logic [7:0] PTR_TEMP_LO   = 8'h10;

    // Protocol phase, one-hot.
    typedef enum logic [6:0] {
        PH_IDLE  = 7'b000_0001,
        PH_ADDR  = 7'b000_0010,
        PH_AACK  = 7'b000_0100,
        PH_WBYTE = 7'b000_1000,
        PH_WACK  = 7'b001_0000,
        PH_RBYTE = 7'b010_0000,
        PH_RACK  = 7'b100_0000
    } phase_e;

    // Conversion engine phase, one-hot.
    typedef enum logic [2:0] {
        CV_IDLE = 3'b001,
        CV_RUN  = 3'b010,
        CV_DOWN = 3'b100
    } conv_e;

    // Analog comparator inputs grouped.
    typedef struct packed {
        logic short_fault;
        logic open_fault;
        logic supply_bad;
    } sense_s;
endpackage : tsense_pkg

// file: testbench/bus_master_model.sv
// Behavioural two-wire bus master that drives the block's serial pins.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input  wire logic CLOCK,    // Bench clock; bus steps land on its falling edge.
    input  wire logic DEV_PULL, // Device pulls data low.
    output var logic  SCL,      // Resolved clock line.
    output var logic  SDA       // Resolved data line.
);
    logic scl_low = 1'b0;
    logic sda_low = 1'b0;
    // Both lines have pull-ups, so a released line reads high, never the last value.
    always_comb begin
        SCL = !scl_low;
        SDA = !(sda_low || DEV_PULL);
    end
    // Half of the 80 ns link period, far above the slowest allowed clock.
    task automatic half();
        repeat (4) @(negedge CLOCK);
    endtask : half
    // Start from idle, or as a repeated start while the clock is low.
    task automatic start();
        sda_low = 1'b0;
        half();
        scl_low = 1'b0;
        half();
        sda_low = 1'b1;
        half();
        scl_low = 1'b1;
    endtask : start
    // One bit: data set while the clock is low, line sampled at the end of high.
    task automatic bit_io(input logic tx, output logic rx);
        sda_low = !tx;
        half();
        scl_low = 1'b0;
        half();
        rx = SDA;
        scl_low = 1'b1;
    endtask : bit_io
    // Eight bits most significant first, then the acknowledge slot.
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, s);
        ack = !s;
    endtask : xfer
    // Stop leaves both lines released, and the clock stands still after it.
    task automatic stop();
        sda_low = 1'b1;
        half();
        scl_low = 1'b0;
        half();
        sda_low = 1'b0;
        half();
    endtask : stop
endmodule : bus_master_model
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the temperature sensor serial control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int STUCK = 200;
    localparam int CONV  = 50;
    logic               clock = 1'b0;
    logic               reset = 1'b1;
    logic               scl;
    logic               sda;
    logic               sda_o;
    logic               sda_oe;
    logic               hs_mode;
    logic               conv_busy;
    logic               analog_on;
    logic [7:0]         result;
    logic [7:0]         rx;
    tsense_pkg::sense_s sense    = '0;
    logic [7:0]         adc      = 8'hA7;
    int                 n_errors = 0;
    int                 n_checks = 0;
    temp_sensor_serial_control #(.STUCK_LIMIT(STUCK), .CONV_LEN(CONV)) i_dut (
        .CLOCK(clock), .RESET(reset), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE(sda_oe), .SENSE(sense), .ADC_DATA(adc), .HS_MODE(hs_mode),
        .CONV_BUSY(conv_busy), .ANALOG_ON(analog_on), .TEMP_RESULT(result));
    bus_master_model i_master (.CLOCK(clock), .DEV_PULL(sda_oe & ~sda_o), .SCL(scl), .SDA(sda));
    // 100 MHz clock.
    initial begin
        forever #5 clock = !clock;
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : check
    task automatic cycles(input int n);
        repeat (n) @(negedge clock);
    endtask : cycles
    // One written byte and the acknowledge that is expected for it.
    task automatic put(input logic [7:0] b, input logic exp_ack);
        logic [7:0] r;
        logic       ack;
        i_master.xfer(b, 1'b1, r, ack);
        check("acknowledge", 8'(exp_ack), 8'(ack));
    endtask : put
    // Single-byte read from the last pointer, ended by a not-acknowledge.
    task automatic rd(output logic [7:0] d);
        logic ack;
        i_master.start();
        put(8'h99, 1'b1);
        i_master.xfer(8'hFF, 1'b1, d, ack);
        i_master.stop();
    endtask : rd
    task automatic sc_convert();
        int busy;
        busy = 0;
        repeat (3 * CONV) begin
            @(negedge clock);
            busy += int'(conv_busy === 1'b1);
        end
        check("busy cycles", 8'h01, 8'(busy >= 3 * CONV - 8));
        check("result", 8'hA4, result);
        sense.open_fault = 1'b1;
        cycles(2 * CONV + 8);
        check("open result", 8'hA5, result);
        sense.open_fault  = 1'b0;
        sense.short_fault = 1'b1;
        cycles(2 * CONV + 8);
        check("short result", 8'h9C, result);
        sense.short_fault = 1'b0;
    endtask : sc_convert
    task automatic sc_supply();
        sense.supply_bad = 1'b1;
        cycles(10);
        check("supply flag", 8'h01, 8'(result[tsense_pkg::SUPPLY_BIT]));
        cycles(2 * CONV);
        check("busy on bad supply", 8'h00, 8'(conv_busy));
        sense.supply_bad = 1'b0;
        cycles(2 * CONV + 8);
        check("recovered result", 8'hA4, result);
    endtask : sc_supply
    // The new raw value already shows from conversions done during the write, and the last one finishes before power-down.
    task automatic sc_power();
        adc = 8'h5C;
        i_master.start();
        put({tsense_pkg::SLAVE_ADDR, 1'b0}, 1'b1);
        put(tsense_pkg::PTR_CFG, 1'b1);
        put(8'h40, 1'b1);
        i_master.stop();
        for (int i = 0; i < CONV + 10 && analog_on !== 1'b0; i++) @(negedge clock);
        check("powered down", 8'h00, 8'(analog_on));
        check("finished result", 8'h5C, result);
        cycles(3 * CONV);
        check("idle when down", 8'h00, 8'(conv_busy));
        rd(rx);
        check("config readback", 8'h40, rx);
    endtask : sc_power
    task automatic sc_gencall();
        i_master.start();
        put(tsense_pkg::GEN_CALL_ADDR, 1'b1);
        put(8'h05, 1'b1);
        i_master.stop();
        cycles(10);
        check("no action", 8'h00, 8'(analog_on));
        i_master.start();
        put(tsense_pkg::GEN_CALL_ADDR, 1'b1);
        put(tsense_pkg::SW_RESET_CODE, 1'b1);
        i_master.stop();
        check("reset power", 8'h01, 8'(analog_on));
        check("reset result", 8'h00, result);
        rd(rx);
        check("reset pointer", 8'h5C, rx);
    endtask : sc_gencall
    task automatic sc_fast();
        logic [7:0] codes [2] = '{8'h08, 8'h0F};
        foreach (codes[k]) begin
            i_master.start();
            put(codes[k], 1'b1);
            put({tsense_pkg::SLAVE_ADDR, 1'b0}, 1'b1);
            check("high speed", 8'h01, 8'(hs_mode));
            put(tsense_pkg::PTR_TEMP, 1'b1);
            i_master.stop();
            cycles(8);
            check("fast again", 8'h00, 8'(hs_mode));
        end
        i_master.start();
        put(8'h20, 1'b0);
        i_master.stop();
    endtask : sc_fast
    // The clock is held low while the device drives a zero data bit.
    task automatic sc_stuck();
        i_master.start();
        put({tsense_pkg::SLAVE_ADDR, 1'b1}, 1'b1);
        cycles(5);
        check("holds data", 8'h01, 8'(sda_oe));
        cycles(STUCK + 20);
        check("released", 8'h00, 8'(sda_oe));
        i_master.start();
        put({tsense_pkg::SLAVE_ADDR, 1'b0}, 1'b1);
        i_master.stop();
    endtask : sc_stuck
    task automatic report_and_stop();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    // Main sequence: reset values, then each scenario in turn.
    initial begin
        cycles(4);
        check("reset pull", 8'h00, 8'(sda_oe));
        check("reset speed", 8'h00, 8'(hs_mode));
        check("reset analog", 8'h01, 8'(analog_on));
        check("reset value", 8'h00, result);
        reset = 1'b0;
        cycles(4);
        sc_convert();
        sc_supply();
        sc_power();
        sc_gencall();
        sc_fast();
        sc_stuck();
        report_and_stop();
    end
    // Watchdog: the scenarios need a little over a quarter of this span.
    initial begin
        #100_000;
        n_errors++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire

// file: testbench/tsense_props.sv
// Concurrent checks on the ports of the temperature sensor serial control block.
`timescale 1ns/1ps
`default_nettype none
module tsense_props #(
    parameter int STUCK_LIMIT = 200, // Bus-stuck cycles.
    parameter int CONV_LEN    = 50   // Cycles per conversion.
) (
    input wire logic               CLOCK,      // System clock.
    input wire logic               RESET,      // Reset, high.
    input wire logic               SCL_I,      // Bus clock level.
    input wire logic               SDA_I,      // Bus data level.
    input wire logic               SDA_O,      // Data driven value.
    input wire logic               SDA_OE,     // Device pulls data.
    input wire tsense_pkg::sense_s SENSE,      // Comparator levels.
    input wire logic [7:0]         ADC_DATA,   // Raw value.
    input wire logic               HS_MODE,    // High-speed filters.
    input wire logic               CONV_BUSY,  // Converting.
    input wire logic               ANALOG_ON,  // Analog powered.
    input wire logic [7:0]         TEMP_RESULT // Result.
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    // Longest wait from a busy sample to the end of that conversion.
    localparam int OPEN_WAIT = CONV_LEN;
    int   fall_age;
    int   stop_age;
    int   scl_lo;
    int   sda_lo;
    logic scl_q;
    logic sda_q;
    function automatic int sat(int v);
        return (v < 100000) ? v + 1 : v;
    endfunction : sat
    // Ages of bus events in cycles; they saturate so a long idle never wraps.
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            fall_age  <= 100;
            stop_age  <= 100;
            scl_lo    <= 0;
            sda_lo    <= 0;
        end else begin
            scl_q     <= SCL_I;
            sda_q     <= SDA_I;
            fall_age  <= (scl_q && !SCL_I) ? 0 : sat(fall_age);
            stop_age  <= (scl_q && SCL_I && !sda_q && SDA_I) ? 0 : sat(stop_age);
            scl_lo    <= SCL_I ? 0 : sat(scl_lo);
            sda_lo    <= SDA_I ? 0 : sat(sda_lo);
        end
    end
    sequence bus_stop_s;
        SCL_I && !SDA_I ##1 SCL_I && SDA_I;
    endsequence
    hs_entry_a: assert property ($rose(HS_MODE) |-> SDA_OE)
        else $error("high-speed entry without acknowledge");
    hs_exit_a: assert property (HS_MODE ##0 bus_stop_s |-> ##[1:8] !HS_MODE)
        else $error("high-speed kept after stop");
    hs_hold_a: assert property ($fell(HS_MODE) |-> stop_age <= 8)
        else $error("high-speed left without stop");
    stuck_release_a: assert property ((scl_lo > STUCK_LIMIT + 10 || sda_lo > STUCK_LIMIT + 10)
        |-> !SDA_OE)
        else $error("data still pulled after bus timeout");
    // A timeout may end a pull on either line, away from any clock fall.
    pull_timing_a: assert property ($changed(SDA_OE)
        |-> fall_age <= 6 || scl_lo >= STUCK_LIMIT || sda_lo >= STUCK_LIMIT)
        else $error("data pull changed away from clock fall");
    power_gate_a: assert property (!ANALOG_ON |-> !CONV_BUSY)
        else $error("conversion while powered down");
    // Powered and idle on a good supply: the next conversion starts, or power-down follows.
    back_to_back_a: assert property (ANALOG_ON && !SENSE.supply_bad && !CONV_BUSY
        |-> ##[1:2] (CONV_BUSY || !ANALOG_ON))
        else $error("conversions not back to back");
    supply_abort_a: assert property (SENSE.supply_bad && CONV_BUSY
        |-> ##[1:3] (!CONV_BUSY && TEMP_RESULT[tsense_pkg::SUPPLY_BIT]))
        else $error("conversion kept on bad supply");
    no_conv_bad_a: assert property ($rose(CONV_BUSY) |-> !$past(SENSE.supply_bad))
        else $error("conversion started on bad supply");
    // An aborted conversion owes no result, so a drop of busy also ends the wait.
    open_flag_a: assert property (SENSE.open_fault && CONV_BUSY && !SENSE.supply_bad
        |-> ##[1:OPEN_WAIT] (TEMP_RESULT[tsense_pkg::OPEN_BIT] || !CONV_BUSY))
        else $error("open fault not flagged");
endmodule : tsense_props
bind temp_sensor_serial_control tsense_props #(.STUCK_LIMIT(STUCK_LIMIT), .CONV_LEN(CONV_LEN))
    i_props (.CLOCK(CLOCK), .RESET(RESET), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
             .SDA_OE(SDA_OE), .SENSE(SENSE), .ADC_DATA(ADC_DATA), .HS_MODE(HS_MODE),
             .CONV_BUSY(CONV_BUSY), .ANALOG_ON(ANALOG_ON), .TEMP_RESULT(TEMP_RESULT));
`default_nettype wire
